// file: rtl/asq_pkg.sv
// Purpose: shared constants and carrier types of the axis sequencer
// Assumes: 125 MHz clock, 32-bit AXI4-Lite register bus
// Notes: values are in 0.01 % units unless named otherwise
package asq_pkg;
  localparam int CLK_MHZ = 125;
  localparam int CLK_HZ = CLK_MHZ * 1_000_000;
  localparam int DEB_TIME_US = 1000;
  localparam int DEB_CYCLES = DEB_TIME_US * CLK_MHZ;
  localparam int FULL_SCALE = 10000;
  localparam int POS_GAIN = 4;
  localparam int RANGE0_MA = 1000;
  localparam int RANGE1_MA = 1600;
  localparam int RANGE2_MA = 2600;
  // input bit positions after debounce
  localparam int DI_EN = 0;
  localparam int DI_RUN = 1;
  localparam int DI_AUTO = 2;
  localparam int DI_SEL1 = 3;
  localparam int DI_SEL2 = 4;
  localparam int DI_SEL4 = 5;
  localparam int DI_SERR = 6;
  localparam int DI_W = 7;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INPOS = 8'h04;
  localparam logic [7:0] OFS_EDECEL = 8'h08;
  localparam logic [7:0] OFS_JOGFWD = 8'h0c;
  localparam logic [7:0] OFS_JOGREV = 8'h10;
  localparam logic [7:0] OFS_NUMX = 8'h14;
  localparam logic [7:0] OFS_DENX = 8'h18;
  localparam logic [7:0] OFS_OFFX = 8'h1c;
  localparam logic [7:0] OFS_NUMW = 8'h20;
  localparam logic [7:0] OFS_DENW = 8'h24;
  localparam logic [7:0] OFS_OFFW = 8'h28;
  localparam logic [7:0] OFS_DFREQ = 8'h2c;
  localparam logic [7:0] OFS_DAMPL = 8'h30;
  localparam logic [7:0] OFS_PWM = 8'h34;
  localparam logic [7:0] OFS_PPWM = 8'h38;
  localparam logic [7:0] OFS_IPWM = 8'h3c;
  localparam logic [7:0] OFS_STAT = 8'h40;
  localparam logic [7:0] OFS_ACTPOS = 8'h44;
  localparam logic [7:0] OFS_IRQST = 8'h48;
  localparam logic [7:0] OFS_IRQMSK = 8'h4c;
  // reset values
  localparam logic [15:0] RST_INPOS = 16'h00c8;
  localparam logic [15:0] RST_EDECEL = 16'h01f4;
  localparam logic [15:0] RST_JOGFWD = 16'h0ce4;
  localparam logic [15:0] RST_JOGREV = 16'hf31c;
  localparam logic [15:0] RST_GAIN = 16'h03e8;
  localparam logic [15:0] RST_DFREQ = 16'h0078;
  localparam logic [15:0] RST_DAMPL = 16'h01f4;
  localparam logic [15:0] RST_PWM = 16'h0a28;
  localparam logic [4:0] RST_PPWM = 5'h03;
  localparam logic [8:0] RST_IPWM = 9'h028;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } asq_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } asq_axi_rsp_t;
  typedef struct packed {
    logic [1:0] rangeSel; logic [15:0] dfreq; logic [15:0] dampl;
    logic [15:0] pwmFreq; logic [4:0] kp; logic [8:0] ki;
  } asq_cur_cfg_t;
endpackage

// file: rtl/asq_debounce.sv
// Purpose: two-flop synchroniser plus stability filter per input bit
// Assumes: inputs may bounce for less than CNT cycles
// Notes: output changes only after CNT equal samples
module asq_debounce import asq_pkg::*; #(
  parameter int W = DI_W,
  parameter int CNT = DEB_CYCLES,
  parameter int CW = $clog2(CNT + 1)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] rawIn,
  output logic [W-1:0] clean
);
  typedef struct packed {
    logic [W-1:0] s1; logic [W-1:0] s2; logic [W-1:0] stable; logic [W-1:0][CW-1:0] cnt;
  } asq_deb_st_t;
  asq_deb_st_t r, next_r;

  always_comb
  begin
    next_r = r;
    next_r.s1 = rawIn;
    next_r.s2 = r.s1;
    for (int i = 0; i < W; i++)
    begin
      if (r.s2[i] == r.stable[i])
        next_r.cnt[i] = '0;
      else if (r.cnt[i] == CW'(CNT - 1))
      begin
        next_r.stable[i] = r.s2[i];
        next_r.cnt[i] = '0;
      end
      else
        next_r.cnt[i] = r.cnt[i] + CW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign clean = r.stable;
endmodule

// file: rtl/asq_current_loop.sv
// Purpose: solenoid current PI loop with square dither and PWM output
// Assumes: measMa is the solenoid current in mA, sampled every PWM period
// Notes: configuration ranges are clamped by the register file
module asq_current_loop import asq_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire asq_cur_cfg_t cfg,
  input wire logic enable,
  input wire logic signed [15:0] setpoint,
  input wire logic signed [15:0] measMa,
  output logic pwmOut
);
  typedef struct packed {
    logic [20:0] pwmCnt; logic [20:0] ditCnt; logic ditHigh;
    logic signed [31:0] integ; logic [20:0] duty; logic pwmOut;
  } asq_cur_st_t;
  asq_cur_st_t r, next_r;

  always_comb
  begin
    int rangeMa, pwmPer, ditHalf, spMa, err, drive;
    next_r = r;
    unique case (cfg.rangeSel) // RULE12
      2'h1: rangeMa = RANGE1_MA;
      2'h2: rangeMa = RANGE2_MA;
      default: rangeMa = RANGE0_MA;
    endcase
    pwmPer = CLK_HZ / int'(cfg.pwmFreq); // RULE14
    ditHalf = CLK_HZ / (2 * int'(cfg.dfreq));
    // square dither rides on the command before scaling RULE13
    spMa = (int'(setpoint) + (r.ditHigh ? int'(cfg.dampl) : -int'(cfg.dampl)));
    spMa = (spMa < 0) ? 0 : spMa * rangeMa / FULL_SCALE;
    err = spMa - int'(measMa);
    drive = 0;
    next_r.ditCnt = r.ditCnt + 21'h1;
    if (int'(r.ditCnt) >= ditHalf - 1)
    begin
      next_r.ditCnt = '0;
      next_r.ditHigh = !r.ditHigh;
    end
    next_r.pwmCnt = r.pwmCnt + 21'h1;
    if (int'(r.pwmCnt) >= pwmPer - 1)
    begin
      next_r.pwmCnt = '0;
      // integrator cleared while output off, avoids windup
      next_r.integ = enable ? r.integ + err : '0; // RULE15
      drive = int'(cfg.kp) * err + int'(next_r.integ) / int'(cfg.ki); // RULE15
      next_r.duty = (drive < 0) ? '0 : (drive > pwmPer) ? 21'(pwmPer) : 21'(drive);
    end
    next_r.pwmOut = enable && (r.pwmCnt < r.duty);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign pwmOut = r.pwmOut;
endmodule

// file: rtl/asq_sequencer.sv
// Purpose: axis positioning sequencer, input scaling and valve current setup
// Assumes: xRaw and wRaw are sampled analog values, measMa the solenoid current
// Notes: registers reached over AXI4-Lite; one interrupt level output
// How it works
// [RULE1] ready is high only while enable is on and no sensor error
// [RULE2] status low beyond half window, high only while run is on
// [RULE3] auto select high gives automatic mode, low gives manual jog mode
// [RULE4] run off, forward jog drives jog output; release loads actual position
// [RULE5] run off, reverse jog drives jog output; release loads actual position
// [RULE6] run on keeps control active and follows the analog command
// [RULE7] run dropped while moving sets command to actual plus stop distance
// [RULE8] enable rising turns output on and loads actual as command
// [RULE9] target address 0 to 7 from select inputs weighted 1, 2, 4
// [RULE10] each input scaled by numerator over denominator times input minus offset
// [RULE11] input type set to current switches that input to current measurement
// [RULE12] two-bit code selects 1.0, 1.6 or 2.6 A current range
// [RULE13] dither 60 to 400 Hz, amplitude 0 to 3000, on current command
// [RULE14] switching frequency 100 to 7700 Hz; low band needs zero dither
// [RULE15] PI current loop, proportional 0 to 30, integral 1 to 500
// [RULE16] in-position window centred on setpoint, 2 to 2000, default 200
// [RULE17] selection trigger off latches on run edge, on follows inputs directly
// [RULE18] digital inputs synchronised and debounced before use
module asq_sequencer import asq_pkg::*; #(
  parameter int DEB_COUNT = DEB_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire asq_axi_req_t axiIn,
  output asq_axi_rsp_t axiOut,
  input wire logic [DI_W-1:0] digIn,
  input wire logic signed [15:0] xRaw,
  input wire logic signed [15:0] wRaw,
  input wire logic signed [15:0] measMa,
  output logic ready,
  output logic inPos,
  output logic outEnable,
  output logic signed [15:0] valveCmd,
  output logic [2:0] targetAddr,
  output logic targetStrobe,
  output logic [1:0] inputCurMode,
  output logic pwmOut,
  output logic irq
);
  typedef struct packed {
    asq_axi_rsp_t ax; logic awHeld; logic [7:0] awAddr; logic wHeld;
    logic [31:0] wData; logic [3:0] wStrb;
    logic dsel; logic [1:0] curRange; logic typeX; logic typeW;
    logic [15:0] inposWin; logic [15:0] edecel;
    logic signed [15:0] jogFwd; logic signed [15:0] jogRev;
    logic [15:0] numX; logic [15:0] denX; logic signed [15:0] offX;
    logic [15:0] numW; logic [15:0] denW; logic signed [15:0] offW;
    logic [15:0] dfreq; logic [15:0] dampl; logic [15:0] pwmFreq;
    logic [4:0] ppwm; logic [8:0] ipwm; logic [3:0] irqStat; logic [3:0] irqMask;
    logic enPrev; logic runPrev; logic fwdPrev; logic revPrev; logic serrPrev;
    logic signed [15:0] cmdPos; logic signed [15:0] valve; logic outEn; logic ready;
    logic inPos; logic [2:0] tgt; logic tgtStb; logic irq;
  } asq_seq_st_t;
  asq_seq_st_t r, next_r;
  logic [DI_W-1:0] din;
  logic signed [15:0] actPos, wCmd;
  logic en, run, autoSel, handFwd, handRev, runRise, runFall, enRise, moving;
  logic [2:0] selAddr;
  int posErr, halfWin;
  asq_cur_cfg_t curCfg;

  function automatic int scaleIn(input logic signed [15:0] v, input logic [15:0] num,
                                 input logic [15:0] den, input logic signed [15:0] off);
    scaleIn = (den == '0) ? 0 : int'(num) * (int'(v) - int'(off)) / int'(den); // RULE10
  endfunction

  function automatic logic [15:0] putReg(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s, input int lo, input int hi);
    logic [15:0] m;
    int v;
    m = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    v = (lo < 0) ? int'($signed(m)) : int'(m);
    // out-of-range writes saturate rather than fault
    putReg = (v < lo) ? 16'(lo) : (v > hi) ? 16'(hi) : m;
  endfunction

  asq_debounce #(.W(DI_W), .CNT(DEB_COUNT)) uDeb ( // RULE18
    .clock(clock),
    .rst_n(rst_n),
    .rawIn(digIn),
    .clean(din)
  );

  assign en = din[DI_EN];
  assign run = din[DI_RUN];
  assign autoSel = din[DI_AUTO];
  assign selAddr = {din[DI_SEL4], din[DI_SEL2], din[DI_SEL1]}; // RULE9
  assign handFwd = !autoSel && !run && din[DI_SEL1]; // RULE3
  assign handRev = !autoSel && !run && din[DI_SEL2] && !din[DI_SEL1]; // RULE3
  assign runRise = run && !r.runPrev;
  assign runFall = !run && r.runPrev;
  assign enRise = en && !r.enPrev;
  assign actPos = 16'(scaleIn(xRaw, r.numX, r.denX, r.offX)); // RULE10
  assign wCmd = 16'(scaleIn(wRaw, r.numW, r.denW, r.offW)); // RULE10
  assign posErr = int'(r.cmdPos) - int'(actPos);
  assign halfWin = int'(r.inposWin) / 2; // RULE16
  assign moving = (posErr > halfWin) || (-posErr > halfWin);
  assign curCfg = '{rangeSel: r.curRange, dfreq: r.dfreq, dampl: r.dampl,
                    pwmFreq: r.pwmFreq, kp: r.ppwm, ki: r.ipwm};

  always_comb
  begin
    int pTerm;
    logic [3:0] ev, clr;
    logic wrOk, rdOk;
    logic [31:0] rd;
    next_r = r;
    ev = '0;
    clr = '0;
    wrOk = 1'b1;
    rdOk = 1'b1;
    rd = '0;
    pTerm = 0;
    // register bus
    if (axiIn.awvalid && r.ax.awready)
    begin
      next_r.awHeld = 1'b1;
      next_r.awAddr = axiIn.awaddr;
    end
    if (axiIn.wvalid && r.ax.wready)
    begin
      next_r.wHeld = 1'b1;
      next_r.wData = axiIn.wdata;
      next_r.wStrb = axiIn.wstrb;
    end
    if (r.ax.bvalid && axiIn.bready)
      next_r.ax.bvalid = 1'b0;
    if (r.awHeld && r.wHeld && !r.ax.bvalid)
    begin
      unique case ({r.awAddr[7:2], 2'b00})
        OFS_CTRL:
        begin
          if (r.wStrb[0])
          begin
            next_r.dsel = r.wData[0];
            next_r.curRange = (r.wData[2:1] == 2'h3) ? 2'h2 : r.wData[2:1]; // RULE12
            next_r.typeX = r.wData[3]; // RULE11
            next_r.typeW = r.wData[4]; // RULE11
          end
        end
        OFS_INPOS: next_r.inposWin = putReg(r.inposWin, r.wData, r.wStrb, 2, 2000); // RULE16
        OFS_EDECEL: next_r.edecel = putReg(r.edecel, r.wData, r.wStrb, 0, FULL_SCALE);
        OFS_JOGFWD: next_r.jogFwd = putReg(r.jogFwd, r.wData, r.wStrb, -FULL_SCALE, FULL_SCALE);
        OFS_JOGREV: next_r.jogRev = putReg(r.jogRev, r.wData, r.wStrb, -FULL_SCALE, FULL_SCALE);
        OFS_NUMX: next_r.numX = putReg(r.numX, r.wData, r.wStrb, 0, FULL_SCALE);
        OFS_DENX: next_r.denX = putReg(r.denX, r.wData, r.wStrb, 0, FULL_SCALE);
        OFS_OFFX: next_r.offX = putReg(r.offX, r.wData, r.wStrb, -FULL_SCALE, FULL_SCALE);
        OFS_NUMW: next_r.numW = putReg(r.numW, r.wData, r.wStrb, 0, FULL_SCALE);
        OFS_DENW: next_r.denW = putReg(r.denW, r.wData, r.wStrb, 0, FULL_SCALE);
        OFS_OFFW: next_r.offW = putReg(r.offW, r.wData, r.wStrb, -FULL_SCALE, FULL_SCALE);
        OFS_DFREQ: next_r.dfreq = putReg(r.dfreq, r.wData, r.wStrb, 60, 400); // RULE13
        OFS_DAMPL: next_r.dampl = putReg(r.dampl, r.wData, r.wStrb, 0, 3000); // RULE13
        OFS_PWM: next_r.pwmFreq = putReg(r.pwmFreq, r.wData, r.wStrb, 100, 7700); // RULE14
        OFS_PPWM: next_r.ppwm = 5'(putReg(16'(r.ppwm), r.wData, r.wStrb, 0, 30)); // RULE15
        OFS_IPWM: next_r.ipwm = 9'(putReg(16'(r.ipwm), r.wData, r.wStrb, 1, 500)); // RULE15
        OFS_IRQST: clr = r.wStrb[0] ? r.wData[3:0] : 4'h0;
        OFS_IRQMSK: next_r.irqMask = r.wStrb[0] ? r.wData[3:0] : r.irqMask;
        OFS_STAT, OFS_ACTPOS: wrOk = 1'b1;
        default: wrOk = 1'b0;
      endcase
      next_r.awHeld = 1'b0;
      next_r.wHeld = 1'b0;
      next_r.ax.bvalid = 1'b1;
      next_r.ax.bresp = wrOk ? RESP_OKAY : RESP_SLVERR;
    end
    next_r.ax.awready = !next_r.awHeld && !next_r.ax.bvalid;
    next_r.ax.wready = !next_r.wHeld && !next_r.ax.bvalid;
    unique case ({axiIn.araddr[7:2], 2'b00})
      OFS_CTRL: rd = {27'h0, r.typeW, r.typeX, r.curRange, r.dsel};
      OFS_INPOS: rd = {16'h0, r.inposWin};
      OFS_EDECEL: rd = {16'h0, r.edecel};
      OFS_JOGFWD: rd = 32'(r.jogFwd);
      OFS_JOGREV: rd = 32'(r.jogRev);
      OFS_NUMX: rd = {16'h0, r.numX};
      OFS_DENX: rd = {16'h0, r.denX};
      OFS_OFFX: rd = 32'(r.offX);
      OFS_NUMW: rd = {16'h0, r.numW};
      OFS_DENW: rd = {16'h0, r.denW};
      OFS_OFFW: rd = 32'(r.offW);
      OFS_DFREQ: rd = {16'h0, r.dfreq};
      OFS_DAMPL: rd = {16'h0, r.dampl};
      OFS_PWM: rd = {16'h0, r.pwmFreq};
      OFS_PPWM: rd = {27'h0, r.ppwm};
      OFS_IPWM: rd = {23'h0, r.ipwm};
      OFS_STAT: rd = {22'h0, r.tgt, din[DI_SERR], autoSel, run, en, r.outEn, r.inPos, r.ready};
      OFS_ACTPOS: rd = 32'(actPos);
      OFS_IRQST: rd = {28'h0, r.irqStat};
      OFS_IRQMSK: rd = {28'h0, r.irqMask};
      default: rdOk = 1'b0;
    endcase
    if (axiIn.arvalid && r.ax.arready)
    begin
      next_r.ax.rvalid = 1'b1;
      next_r.ax.rdata = rdOk ? rd : 32'h0;
      next_r.ax.rresp = rdOk ? RESP_OKAY : RESP_SLVERR;
    end
    else if (r.ax.rvalid && axiIn.rready)
      next_r.ax.rvalid = 1'b0;
    next_r.ax.arready = !next_r.ax.rvalid;
    // positioning control
    next_r.enPrev = en;
    next_r.runPrev = run;
    next_r.fwdPrev = handFwd;
    next_r.revPrev = handRev;
    next_r.serrPrev = din[DI_SERR];
    pTerm = posErr * POS_GAIN;
    pTerm = (pTerm > FULL_SCALE) ? FULL_SCALE : (pTerm < -FULL_SCALE) ? -FULL_SCALE : pTerm;
    next_r.outEn = en;
    if (!en)
      next_r.valve = '0;
    else if (handFwd)
      next_r.valve = r.jogFwd; // RULE4
    else if (handRev)
      next_r.valve = r.jogRev; // RULE5
    else
      next_r.valve = 16'(pTerm); // RULE6
    if (run)
      next_r.cmdPos = wCmd; // RULE6
    else if (runFall && moving)
    begin
      // stop distance applied in the direction of travel
      next_r.cmdPos = 16'(int'(actPos) + (posErr > 0 ? int'(r.edecel) : -int'(r.edecel))); // RULE7
      ev[1] = 1'b1;
    end
    else if ((r.fwdPrev && !handFwd) || (r.revPrev && !handRev))
      next_r.cmdPos = actPos; // RULE4 RULE5
    if (enRise)
    begin
      next_r.cmdPos = actPos; // RULE8
      ev[0] = 1'b1;
    end
    next_r.ready = en && !din[DI_SERR]; // RULE1
    next_r.inPos = en && run && !moving; // RULE2 RULE16
    ev[2] = din[DI_SERR] && !r.serrPrev;
    ev[3] = r.inPos && !next_r.inPos && run;
    next_r.tgtStb = 1'b0;
    if (autoSel && r.dsel && selAddr != r.tgt)
    begin
      next_r.tgt = selAddr; // RULE17
      next_r.tgtStb = 1'b1;
    end
    else if (autoSel && !r.dsel && runRise)
    begin
      next_r.tgt = selAddr; // RULE17
      next_r.tgtStb = 1'b1;
    end
    // a new event wins over a clear in the same cycle
    next_r.irqStat = (r.irqStat & ~clr) | ev;
    next_r.irq = |(next_r.irqStat & next_r.irqMask);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.ax.awready <= 1'b1;
      r.ax.wready <= 1'b1;
      r.ax.arready <= 1'b1;
      r.inposWin <= RST_INPOS;
      r.edecel <= RST_EDECEL;
      r.jogFwd <= RST_JOGFWD;
      r.jogRev <= RST_JOGREV;
      r.numX <= RST_GAIN;
      r.denX <= RST_GAIN;
      r.numW <= RST_GAIN;
      r.denW <= RST_GAIN;
      r.dfreq <= RST_DFREQ;
      r.dampl <= RST_DAMPL;
      r.pwmFreq <= RST_PWM;
      r.ppwm <= RST_PPWM;
      r.ipwm <= RST_IPWM;
    end
    else
      r <= next_r;
  end

  asq_current_loop uCur (
    .clock(clock),
    .rst_n(rst_n),
    .cfg(curCfg),
    .enable(r.outEn),
    .setpoint(r.valve < 0 ? -r.valve : r.valve),
    .measMa(measMa),
    .pwmOut(pwmOut)
  );

  assign axiOut = r.ax;
  assign ready = r.ready;
  assign inPos = r.inPos;
  assign outEnable = r.outEn;
  assign valveCmd = r.valve;
  assign targetAddr = r.tgt;
  assign targetStrobe = r.tgtStb;
  assign inputCurMode = {r.typeW, r.typeX}; // RULE11
  assign irq = r.irq;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ready_needs_enable: assert property (ready |-> $past(en) && !$past(din[DI_SERR])) // RULE1
    else $error("ready without enable or with sensor error");
  a_status_needs_run: assert property (inPos |-> $past(run)) // RULE2
    else $error("status high while run off");
  a_status_window: assert property ($past(run && en && !moving) |-> inPos) // RULE16
    else $error("status low inside window");
  a_jog_forward: assert property (en && handFwd |=> valveCmd == $past(r.jogFwd)) // RULE4
    else $error("forward jog output wrong");
  a_jog_reverse: assert property (en && handRev |=> valveCmd == $past(r.jogRev)) // RULE5
    else $error("reverse jog output wrong");
  a_run_tracks_cmd: assert property (run && !enRise |=> r.cmdPos == $past(wCmd)) // RULE6
    else $error("command not taken from analog input");
  a_emergency_stop: assert property (runFall && moving && !enRise && posErr > 0
    |=> r.cmdPos == 16'($past(int'(actPos)) + $past(int'(r.edecel)))) // RULE7
    else $error("stop distance not applied");
  a_enable_init: assert property (enRise |=> outEnable && r.cmdPos == $past(actPos)) // RULE8
    else $error("enable did not load actual position");
  a_target_hold: assert property (!runRise && !r.dsel |=> $stable(targetAddr)) // RULE17
    else $error("target changed without run edge");
  a_target_latch: assert property (autoSel && !r.dsel && runRise
    |=> targetAddr == $past(selAddr) && targetStrobe) // RULE9
    else $error("target address not latched");
  a_range_legal: assert property (r.curRange != 2'h3) // RULE12
    else $error("illegal current range code");
  c_jog_release: cover property (handFwd ##1 !handFwd);
  c_emergency: cover property (runFall && moving);
  c_target_run: cover property (runRise && autoSel && !r.dsel);
  c_irq_raise: cover property ($rose(irq));
endmodule

// file: verif/asq_far_side.sv
// Purpose: far side model: position sensor, command source, valve coil
// Assumes: sensor and command follow the bench set points
// Notes: coil current only ramps with the drive, no hydraulics
module asq_far_side (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pwmOut,
  input wire logic signed [15:0] posSet,
  input wire logic signed [15:0] cmdSet,
  output logic signed [15:0] xRaw,
  output logic signed [15:0] wRaw,
  output logic signed [15:0] measMa
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xRaw <= '0;
      wRaw <= '0;
      measMa <= '0;
    end
    else
    begin
      xRaw <= posSet;
      wRaw <= cmdSet;
      // coil lags the drive, never jumps
      if (pwmOut && measMa < 16'sd3000)
        measMa <= measMa + 16'sd1;
      else if (!pwmOut && measMa > 16'sd0)
        measMa <= measMa - 16'sd1;
    end
  end
endmodule

// file: verif/asq_sequencer_tb.sv
// Purpose: register and digital input sequences against the sequencer
// Assumes: short debounce count, always-ready response channels
// Notes: valve side held still, so position error comes from the command
module asq_sequencer_tb import asq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEB = 4;
  localparam int EN = 1 << DI_EN;
  localparam int RUN = 1 << DI_RUN;
  localparam int AUT = 1 << DI_AUTO;
  localparam int S1 = 1 << DI_SEL1;
  localparam logic [23:0] RV [13] = '{{OFS_INPOS, RST_INPOS}, {OFS_EDECEL, RST_EDECEL},
    {OFS_JOGFWD, RST_JOGFWD}, {OFS_JOGREV, RST_JOGREV}, {OFS_NUMX, RST_GAIN},
    {OFS_DENW, RST_GAIN}, {OFS_OFFX, 16'h0}, {OFS_DFREQ, RST_DFREQ}, {OFS_DAMPL, RST_DAMPL},
    {OFS_PWM, RST_PWM}, {OFS_PPWM, 11'h0, RST_PPWM}, {OFS_IPWM, 7'h0, RST_IPWM},
    {OFS_IRQMSK, 16'h0}};
  localparam logic [39:0] SV [8] = '{{OFS_INPOS, 16'h0001, 16'h0002},
    {OFS_DFREQ, 16'h01f4, 16'h0190}, {OFS_PWM, 16'h0032, 16'h0064},
    {OFS_PWM, 16'h1f40, 16'h1e14}, {OFS_DAMPL, 16'h0fa0, 16'h0bb8},
    {OFS_PPWM, 16'h001f, 16'h001e}, {OFS_IPWM, 16'h0000, 16'h0001},
    {OFS_NUMX, 16'h4e20, 16'h2710}};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  asq_axi_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
  asq_axi_rsp_t rsp;
  logic [DI_W-1:0] din = '0;
  logic signed [15:0] posSet = 16'sd1000;
  logic signed [15:0] cmdSet = 16'sd1000;
  logic signed [15:0] xRaw, wRaw, measMa, valveCmd;
  logic ready, inPos, outEnable, targetStrobe, pwmOut, irq;
  logic [2:0] targetAddr;
  logic [1:0] inputCurMode, rr;
  logic [31:0] rd;
  int n_mismatch = 0;
  int check_count = 0;
  int nStb = 0;

  always #4 clock = ~clock;

  // strobe lasts one cycle, so count it at every edge
  always @(posedge clock)
  begin
    if (targetStrobe)
      nStb <= nStb + 1;
  end

  asq_sequencer #(.DEB_COUNT(DEB)) dut_u (.clock(clock), .rst_n(rst_n), .axiIn(req),
    .axiOut(rsp), .digIn(din), .xRaw(xRaw), .wRaw(wRaw), .measMa(measMa), .ready(ready),
    .inPos(inPos), .outEnable(outEnable), .valveCmd(valveCmd), .targetAddr(targetAddr),
    .targetStrobe(targetStrobe), .inputCurMode(inputCurMode), .pwmOut(pwmOut), .irq(irq));
  asq_far_side far_u (.clock(clock), .rst_n(rst_n), .pwmOut(pwmOut), .posSet(posSet),
    .cmdSet(cmdSet), .xRaw(xRaw), .wRaw(wRaw), .measMa(measMa));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // response channels stay ready, so only the requests are released
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clock);
      if (req.awvalid && rsp.awready)
      begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready)
      begin
        w = 1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!rsp.bvalid);
    rr = rsp.bresp;
  endtask

  task rdReg(input logic [7:0] a);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge clock); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge clock); while (!rsp.rvalid);
    rd = rsp.rdata;
    rr = rsp.rresp;
  endtask

  // inputs pass two sync flops and the debounce count first
  task setIn(input int v);
    din <= v[DI_W-1:0];
    repeat (DEB + 8) @(posedge clock);
  endtask

  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 13; i++)
    begin
      rdReg(RV[i][23:16]);
      chk(rd[15:0], RV[i][15:0]);
    end
    // low pwm band is visited below, dither must be off there
    wr(OFS_DAMPL, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(SV[i][39:32], SV[i][31:16]);
      rdReg(SV[i][39:32]);
      chk(rd[15:0], SV[i][15:0]);
    end
    // gain of ten on the position input, then back to defaults
    rdReg(OFS_ACTPOS);
    chk(rd[15:0], 16'd10000);
    wr(OFS_NUMX, RST_GAIN);
    wr(OFS_INPOS, RST_INPOS);
    wr(8'h50, 32'h1);
    chk(rr, RESP_SLVERR);
    rdReg(8'h50);
    chk(rd, 32'h0);
    chk(rr, RESP_SLVERR);
    // code 3 is not a range, it must read back as the top one
    for (int r = 0; r < 4; r++)
    begin
      wr(OFS_CTRL, 32'h9 | (r << 1));
      rdReg(OFS_CTRL);
      chk(rd[4:0], 32'h9 | ((r > 2 ? 2 : r) << 1));
    end
    chk(inputCurMode, 2'b01);
    chk(pwmOut, 1'b0);
    setIn(EN);
    chk(ready, 1'b1);
    chk(outEnable, 1'b1);
    chk(irq, 1'b0);
    rdReg(OFS_IRQST);
    chk(rd[0], 1'b1);
    wr(OFS_IRQMSK, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 1'b1);
    wr(OFS_IRQST, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    setIn(EN | (1 << DI_SERR));
    chk(ready, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      setIn(EN | AUT | (i << DI_SEL1));
      chk(targetAddr, i);
    end
    setIn(EN | S1);
    chk({valveCmd}, RST_JOGFWD);
    setIn(EN | (1 << DI_SEL2));
    chk({valveCmd}, RST_JOGREV);
    wr(OFS_CTRL, 32'h8);
    wr(OFS_IRQST, 32'hf);
    cmdSet <= 16'sd1050;
    setIn(EN | AUT | S1 | (1 << DI_SEL4));
    setIn(EN | AUT | S1 | (1 << DI_SEL4) | RUN);
    chk(targetAddr, 3'd5);
    chk(inPos, 1'b1);
    chk({valveCmd}, 16'd200);
    cmdSet <= 16'sd1300;
    repeat (6) @(posedge clock);
    chk(inPos, 1'b0);
    chk({valveCmd}, 16'd1200);
    setIn(EN | AUT | S1 | (1 << DI_SEL4));
    rdReg(OFS_IRQST);
    chk(rd[3:0], 4'ha);
    chk({valveCmd}, 16'd2000);
    chk(nStb, 8);
    end_sim;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_sim;
  end
endmodule
